// >>> hw/cpu_event_vectoring_unit.sv
// What this block does
// - either reset clears status registers; only debug reset flushes, clears pc, fetches from zero
// - every vector spans two words for prefix plus absolute branch
// - configured internal errors trap as hardware exceptions
// - with float unit, the five float conditions also trap
// - hardware exception flushes, jumps to 0x20, saves decode pc in r17
// - execute instruction in the exception cycle is killed
// - exception clears enable, sets in-progress, loads causes; return reverts
// - exception in a delay slot is flagged non-recoverable
// - break lets execute finish and replaces decode with jump 0x18
// - break saves decode pc in r16 and sets break in progress
// - maskable break taken only while break in progress is zero
// - break in progress suppresses interrupts and exceptions
// - non-maskable break taken at the next boundary regardless of break in progress
// - return from break clears break in progress
// - one interrupt input, honoured only while interrupt enable is one
// - interrupt finishes execute, replaces decode with jump 0x10, saves r14
// - taking interrupt clears enable; return from interrupt sets it
// - interrupt ignored while break in progress is one
// - worst entry latency with divider bounded by 37 or 39 cycles
// - user exception is a software branch-and-link to 0x8, r15 advised
// - priority reset, exception, non-maskable break, break, interrupt
`timescale 1ns/10ps
module cpu_event_vectoring_unit
	import event_pkg::*;
#(
	parameter bit USE_HW_EXCEPTIONS = 1'b1,
	parameter bit USE_FPU           = 1'b1
) (
	// clock and resets
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic        debug_reset_i,
	// external event sources
	input  wire logic        maskable_break_input_i,
	input  wire logic        nonmaskable_break_input_i,
	input  wire logic        interrupt_i,
	// pipeline status
	input  wire logic        boundary_i,
	input  wire logic [31:0] decode_pc_i,
	input  wire exc_report_t exc_i,
	input  wire return_op_t  return_i,
	input  wire logic        status_write_i,
	input  wire logic [31:0] status_wdata_i,
	// pipeline control
	output redirect_t        redirect_o,
	output event_t           event_o,
	// architectural status
	output logic [31:0]      machine_status_register_o,
	output logic [31:0]      exception_status_register_o,
	output logic [31:0]      fault_address_register_o,
	output logic [31:0]      float_status_register_o,
	output logic             unrecoverable_o
);
	// the vector table layout only works with two-word slots
	if (VECTOR_SPAN != 32'h0000_0008) begin : g_span_check
		$error("vector span must be two words");
	end

	typedef struct packed {
		redirect_t   redirect;
		event_t      ev;
		logic [31:0] machine_status;
		logic [31:0] exc_status;
		logic [31:0] fault_addr;
		logic [31:0] float_status;
		logic        unrecoverable;
		logic        irq_s;
		logic        brk_s;
		logic        nmi_s;
		logic        nmi_pend;
	} state_t;

	state_t state_q;
	state_t state_d;

	// pick the cause code of a pipeline exception report
	function automatic logic [4:0] cause_of(input exc_report_t e, input bit fpu_on);
		logic [4:0] c;
		c = 5'h00;
		if (e.unaligned) c = CAUSE_UNALIGNED;
		else if (e.illegal) c = CAUSE_ILLEGAL;
		else if (e.ibus) c = CAUSE_IBUS;
		else if (e.dbus) c = CAUSE_DBUS;
		else if (e.div_zero) c = CAUSE_DIV_ZERO;
		else if (fpu_on && (e.fpu_flags != 5'h00)) c = CAUSE_FPU;
		return c;
	endfunction

	logic [4:0] cause;
	logic       exc_req;
	logic       any_reset;

	// decode the pipeline report; the configuration gates which errors trap
	always_comb begin
		cause = USE_HW_EXCEPTIONS ? cause_of(exc_i, USE_FPU) : 5'h00;
		exc_req = (cause != 5'h00) && !state_q.machine_status[BIT_BRK_BUSY];
		any_reset = reset_i | debug_reset_i;
	end

	// event arbitration and architectural side effects
	always_comb begin
		state_d = state_q;
		state_d.redirect = '0;
		state_d.ev = EV_NONE;
		// inputs are registered once; the core clock is their only clock
		state_d.irq_s = interrupt_i;
		state_d.brk_s = maskable_break_input_i;
		state_d.nmi_s = nonmaskable_break_input_i;
		// a non-maskable edge is latched so it waits for the next boundary
		if (nonmaskable_break_input_i && !state_q.nmi_s) begin
			state_d.nmi_pend = 1'b1;
		end
		// returns retire first so a new event in the same cycle still wins
		if (return_i.from_exception) begin
			state_d.machine_status[BIT_EXC_EN] = 1'b1;
			state_d.machine_status[BIT_EXC_BUSY] = 1'b0;
		end
		if (return_i.from_break) begin
			state_d.machine_status[BIT_BRK_BUSY] = 1'b0;
		end
		if (return_i.from_interrupt) begin
			state_d.machine_status[BIT_INT_EN] = 1'b1;
		end
		if (status_write_i) begin
			state_d.machine_status = status_wdata_i;
		end
		// exceptions are taken at once; external events wait for a boundary
		if (exc_req) begin
			state_d.ev = EV_HW_EXC;
			state_d.redirect.valid = 1'b1;
			state_d.redirect.flush_decode = 1'b1;
			state_d.redirect.kill_execute = 1'b1;
			state_d.redirect.target = HW_EXC_VECTOR;
			state_d.redirect.link_write = 1'b1;
			state_d.redirect.link_reg = LINK_HW_EXC;
			state_d.redirect.link_value = decode_pc_i;
			state_d.machine_status[BIT_EXC_EN] = 1'b0;
			state_d.machine_status[BIT_EXC_BUSY] = 1'b1;
			state_d.exc_status = {20'h0_0000, exc_i.detail, cause};
			state_d.fault_addr = exc_i.address;
			state_d.float_status = {27'h000_0000, exc_i.fpu_flags};
			// recovery is impossible when the faulting op sat in a delay slot
			state_d.unrecoverable = exc_i.in_delay_slot;
		end else if (boundary_i && (state_q.nmi_pend || state_q.nmi_s)) begin
			state_d.ev = EV_NM_BREAK;
			// a fresh edge in the taking cycle must not be lost: set wins over clear
			state_d.nmi_pend = nonmaskable_break_input_i && !state_q.nmi_s;
			state_d.redirect.valid = 1'b1;
			state_d.redirect.flush_decode = 1'b1;
			state_d.redirect.target = BREAK_VECTOR;
			state_d.redirect.link_write = 1'b1;
			state_d.redirect.link_reg = LINK_BREAK;
			state_d.redirect.link_value = decode_pc_i;
			state_d.machine_status[BIT_BRK_BUSY] = 1'b1;
		end else if (boundary_i && state_q.brk_s && !state_q.machine_status[BIT_BRK_BUSY]) begin
			state_d.ev = EV_BREAK;
			state_d.redirect.valid = 1'b1;
			state_d.redirect.flush_decode = 1'b1;
			state_d.redirect.target = BREAK_VECTOR;
			state_d.redirect.link_write = 1'b1;
			state_d.redirect.link_reg = LINK_BREAK;
			state_d.redirect.link_value = decode_pc_i;
			state_d.machine_status[BIT_BRK_BUSY] = 1'b1;
		end else if (boundary_i && state_q.irq_s && state_q.machine_status[BIT_INT_EN]
				&& !state_q.machine_status[BIT_BRK_BUSY]) begin
			state_d.ev = EV_INTERRUPT;
			state_d.redirect.valid = 1'b1;
			state_d.redirect.flush_decode = 1'b1;
			state_d.redirect.target = INTERRUPT_VECTOR;
			state_d.redirect.link_write = 1'b1;
			state_d.redirect.link_reg = LINK_INTERRUPT;
			state_d.redirect.link_value = decode_pc_i;
			state_d.machine_status[BIT_INT_EN] = 1'b0;
		end
		// reset outranks everything and restarts fetch at zero
		if (any_reset) begin
			state_d = '0;
			state_d.ev = EV_RESET;
			state_d.redirect.valid = 1'b1;
			state_d.redirect.flush_decode = 1'b1;
			state_d.redirect.kill_execute = 1'b1;
			state_d.redirect.target = RESET_VECTOR;
			state_d.machine_status = STATUS_RESET;
			state_d.exc_status = ZERO_WORD;
			state_d.fault_addr = ZERO_WORD;
		end
	end

	// single state register; it adds one decision cycle to the pipeline's entry latency
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// outputs straight from the state register
	assign redirect_o = state_q.redirect;
	assign event_o = state_q.ev;
	assign machine_status_register_o = state_q.machine_status;
	assign exception_status_register_o = state_q.exc_status;
	assign fault_address_register_o = state_q.fault_addr;
	assign float_status_register_o = state_q.float_status;
	assign unrecoverable_o = state_q.unrecoverable;
endmodule

// >>> inc/event_pkg.sv
package event_pkg;
	// vector addresses, each two words long so a prefix plus absolute branch fits
	localparam logic [31:0] RESET_VECTOR     = 32'h0000_0000;
	localparam logic [31:0] USER_VECTOR      = 32'h0000_0008;
	localparam logic [31:0] INTERRUPT_VECTOR = 32'h0000_0010;
	localparam logic [31:0] BREAK_VECTOR     = 32'h0000_0018;
	localparam logic [31:0] HW_EXC_VECTOR    = 32'h0000_0020;
	localparam logic [31:0] VECTOR_SPAN      = 32'h0000_0008;
	// return address registers
	localparam logic [4:0] LINK_INTERRUPT = 5'h0E;
	localparam logic [4:0] LINK_USER      = 5'h0F;
	localparam logic [4:0] LINK_BREAK     = 5'h10;
	localparam logic [4:0] LINK_HW_EXC    = 5'h11;
	// status register bit positions (lsb numbering)
	localparam int BIT_INT_EN    = 1;
	localparam int BIT_BRK_BUSY  = 3;
	localparam int BIT_EXC_EN    = 8;
	localparam int BIT_EXC_BUSY  = 9;
	// reset values
	localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
	localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
	// minimum reset hold
	localparam int RESET_HOLD_CYCLES = 16;
	// exception cause codes
	localparam logic [4:0] CAUSE_UNALIGNED = 5'h01;
	localparam logic [4:0] CAUSE_ILLEGAL   = 5'h02;
	localparam logic [4:0] CAUSE_IBUS      = 5'h03;
	localparam logic [4:0] CAUSE_DBUS      = 5'h04;
	localparam logic [4:0] CAUSE_DIV_ZERO  = 5'h05;
	localparam logic [4:0] CAUSE_FPU       = 5'h06;

	// exception report from the pipeline
	typedef struct packed {
		logic        unaligned;
		logic        illegal;
		logic        ibus;
		logic        dbus;
		logic        div_zero;
		logic [4:0]  fpu_flags;    // io, dz, of, uf, do
		logic [6:0]  detail;       // word, store, register
		logic [31:0] address;
		logic        in_delay_slot;
	} exc_report_t;

	// return instructions retiring in execute
	typedef struct packed {
		logic from_exception;
		logic from_break;
		logic from_interrupt;
	} return_op_t;

	typedef enum logic [2:0] {
		EV_NONE      = 3'b000,
		EV_RESET     = 3'b001,
		EV_HW_EXC    = 3'b010,
		EV_NM_BREAK  = 3'b011,
		EV_BREAK     = 3'b100,
		EV_INTERRUPT = 3'b101
	} event_t;

	// redirect command to the pipeline
	typedef struct packed {
		logic        valid;
		logic        flush_decode;
		logic        kill_execute;
		logic [31:0] target;
		logic        link_write;
		logic [4:0]  link_reg;
		logic [31:0] link_value;
	} redirect_t;
endpackage

// >>> tb/cpu_event_vectoring_unit_monitor.sv
`timescale 1ns/10ps
module cpu_event_vectoring_unit_monitor
	import event_pkg::*;
(
	// clock, resets and event inputs
	input wire logic        mclk_i,
	input wire logic        reset_i,
	input wire logic        debug_reset_i,
	input wire logic        nonmaskable_break_input_i,
	input wire logic        boundary_i,
	// pipeline side
	input wire logic [31:0] decode_pc_i,
	input wire exc_report_t exc_i,
	input wire return_op_t  return_i,
	input wire logic        status_write_i,
	input wire redirect_t   redirect_o,
	input wire event_t      event_o,
	input wire logic [31:0] machine_status_register_o
);
	// gate permits, widened by same-cycle returns and writes since those land first
	wire logic [31:0] m     = machine_status_register_o;
	wire logic        ie_ok = m[BIT_INT_EN] | return_i.from_interrupt | status_write_i;
	wire logic        bp_ok = !m[BIT_BRK_BUSY] | return_i.from_break | status_write_i;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	property p_dbg;
		debug_reset_i |=> event_o == EV_RESET && redirect_o.target == RESET_VECTOR && m == STATUS_RESET; endproperty
	a_dbg: assert property (p_dbg) else $error("debug reset not taken");
	property p_exc_take;
		exc_i.illegal && !m[BIT_BRK_BUSY] && !debug_reset_i && !status_write_i
		|=> event_o == EV_HW_EXC && redirect_o.link_value == $past(decode_pc_i); endproperty
	a_exc_take: assert property (p_exc_take) else $error("exception not taken");
	property p_exc_vec;
		event_o == EV_HW_EXC |-> redirect_o.target == HW_EXC_VECTOR && redirect_o.link_reg == LINK_HW_EXC
		&& redirect_o.kill_execute && !m[BIT_EXC_EN] && m[BIT_EXC_BUSY]; endproperty
	a_exc_vec: assert property (p_exc_vec) else $error("exception entry wrong");
	property p_brk;
		event_o == EV_BREAK |-> redirect_o.target == BREAK_VECTOR && redirect_o.link_reg == LINK_BREAK
		&& !redirect_o.kill_execute && m[BIT_BRK_BUSY] && $past(bp_ok); endproperty
	a_brk: assert property (p_brk) else $error("break entry wrong");
	property p_irq;
		event_o == EV_INTERRUPT |-> redirect_o.target == INTERRUPT_VECTOR && redirect_o.link_reg == LINK_INTERRUPT
		&& !redirect_o.kill_execute && !m[BIT_INT_EN]; endproperty
	a_irq: assert property (p_irq) else $error("interrupt entry wrong");
	property p_irq_gate;
		event_o == EV_INTERRUPT |-> $past(ie_ok) && $past(bp_ok); endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt taken while gated");
	property p_nm;
		nonmaskable_break_input_i ##1 boundary_i && !debug_reset_i |=> event_o inside {EV_NM_BREAK, EV_HW_EXC}; endproperty
	a_nm: assert property (p_nm) else $error("nonmaskable break missed");
	property p_rtb;
		return_i.from_break && !status_write_i |=> !m[BIT_BRK_BUSY] || event_o inside {EV_RESET, EV_NM_BREAK, EV_BREAK};
	endproperty
	a_rtb: assert property (p_rtb) else $error("break flag not cleared");
	c_irq: cover property (event_o == EV_INTERRUPT);
	c_nm: cover property (event_o == EV_NM_BREAK);
	c_exc: cover property (event_o == EV_HW_EXC);
endmodule
bind cpu_event_vectoring_unit cpu_event_vectoring_unit_monitor mon (.mclk_i, .reset_i, .debug_reset_i,
	.nonmaskable_break_input_i, .boundary_i, .decode_pc_i, .exc_i, .return_i, .status_write_i, .redirect_o, .event_o,
	.machine_status_register_o);

// >>> tb/event_source_model.sv
`timescale 1ns/10ps
// far side: debugger reset and external event lines, changed just after the edge
module event_source_model
	import event_pkg::*;
(
	// requests from the bench, sampled on the edge
	input  wire logic       mclk_i,
	input  wire logic       debug_req_i,
	input  wire logic [2:0] raise_i,
	// lines into the core
	output logic            debug_reset_o,
	output logic            nonmaskable_break_o,
	output logic            maskable_break_o,
	output logic            interrupt_o
);
	int         hold = 0;
	logic       req;
	logic [2:0] lines;
	initial {debug_reset_o, nonmaskable_break_o, maskable_break_o, interrupt_o} = 4'h0;
	// a one-cycle request still yields the full minimum hold, so the core never sees a glitch
	always @(posedge mclk_i) begin
		req = debug_req_i;
		lines = raise_i;
		#1;
		hold = req ? RESET_HOLD_CYCLES : (hold > 0 ? hold - 1 : 0);
		debug_reset_o = hold > 0;
		{nonmaskable_break_o, maskable_break_o, interrupt_o} = lines;
	end
endmodule

// >>> tb/test_cpu_event_vectoring_unit.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_errors++; $display("unexpected %s expected %h seen %h", n, e, a); end end
module test_cpu_event_vectoring_unit;
	import event_pkg::*;
	logic        mclk_i = 1'b0, reset_i = 1'b1, debug_req = 1'b0, boundary_i = 1'b1, status_write_i = 1'b0;
	logic [2:0]  raise = 3'h0;
	logic [31:0] decode_pc_i = 32'h0000_0000, status_wdata_i = 32'h0000_0002, mstat, estat, faddr, fstat;
	logic        debug_reset_i, maskable_break_input_i, nonmaskable_break_input_i, interrupt_i, unrecoverable_o;
	exc_report_t exc_i = '0;
	return_op_t  return_i = '0;
	redirect_t   redirect_o;
	event_t      event_o;
	int          n_errors = 0, comparisons = 0;
	event_source_model src (.mclk_i, .debug_req_i(debug_req), .raise_i(raise), .debug_reset_o(debug_reset_i),
		.nonmaskable_break_o(nonmaskable_break_input_i), .maskable_break_o(maskable_break_input_i), .interrupt_o(interrupt_i));
	cpu_event_vectoring_unit dut (.mclk_i, .reset_i, .debug_reset_i, .maskable_break_input_i, .nonmaskable_break_input_i,
		.interrupt_i, .boundary_i, .decode_pc_i, .exc_i, .return_i, .status_write_i, .status_wdata_i, .redirect_o, .event_o,
		.machine_status_register_o(mstat), .exception_status_register_o(estat), .fault_address_register_o(faddr),
		.float_status_register_o(fstat), .unrecoverable_o);
	initial forever #20 mclk_i = ~mclk_i;
	// hang guard, far beyond the 66 cycles the sequence needs
	initial begin
		repeat (600) @(posedge mclk_i);
		n_errors++;
		give_verdict();
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// inputs move one step after the edge so the core samples settled values
	task automatic tick(int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic expect_ev(event_t e, logic [31:0] tgt, logic [4:0] lr, logic kill);
		`CHK("event", {e, tgt}, {event_o, redirect_o.target})
		`CHK("link", {2'b11, lr, decode_pc_i, kill},
			{redirect_o.valid, redirect_o.link_write, redirect_o.link_reg, redirect_o.link_value, redirect_o.kill_execute})
	endtask
	initial begin
		void'($urandom(39));
		tick(6);
		reset_i = 1'b0;
		tick(1);
		`CHK("reset status", 128'h0, {mstat, estat, faddr, fstat})
		status_write_i = 1'b1;
		tick(1);
		status_write_i = 1'b0;
		debug_req = 1'b1;
		tick(1);
		debug_req = 1'b0;
		repeat (16) begin
			tick(1);
			`CHK("debug reset", {EV_RESET, RESET_VECTOR}, {event_o, redirect_o.target})
		end
		tick(1);
		`CHK("after debug reset", {EV_NONE, STATUS_RESET}, {event_o, mstat})
		$display("test reset done");
		// interrupt held off by a long instruction, then masked by its own entry
		decode_pc_i = $urandom;
		status_write_i = 1'b1;
		boundary_i = 1'b0;
		raise = 3'b001;
		tick(1);
		status_write_i = 1'b0;
		tick(4);
		`CHK("held off", EV_NONE, event_o)
		boundary_i = 1'b1;
		tick(1);
		expect_ev(EV_INTERRUPT, INTERRUPT_VECTOR, LINK_INTERRUPT, 1'b0);
		tick(3);
		`CHK("masked", {EV_NONE, 1'b0}, {event_o, mstat[BIT_INT_EN]})
		raise = 3'b000;
		tick(3);
		return_i.from_interrupt = 1'b1;
		tick(1);
		return_i = '0;
		`CHK("reenabled", 1'b1, mstat[BIT_INT_EN])
		$display("test interrupt done");
		// top address corner, then interrupt, break and exception are shut out while the break runs
		decode_pc_i = 32'hFFFF_FFFC;
		raise = 3'b010;
		tick(3);
		expect_ev(EV_BREAK, BREAK_VECTOR, LINK_BREAK, 1'b0);
		raise = 3'b011;
		exc_i.illegal = 1'b1;
		repeat (4) begin
			tick(1);
			`CHK("suppressed", {EV_NONE, 1'b1}, {event_o, mstat[BIT_BRK_BUSY]})
		end
		exc_i = '0;
		raise = 3'b100;
		tick(1);
		raise = 3'b000;
		tick(2);
		expect_ev(EV_NM_BREAK, BREAK_VECTOR, LINK_BREAK, 1'b0);
		return_i.from_break = 1'b1;
		tick(1);
		return_i = '0;
		`CHK("break cleared", 1'b0, mstat[BIT_BRK_BUSY])
		$display("test break done");
		for (int i = 0; i < 6; i++) begin
			decode_pc_i = $urandom;
			exc_i = '0;
			exc_i.detail = 7'($urandom);
			exc_i.address = $urandom;
			if (i < 5)
				{exc_i.unaligned, exc_i.illegal, exc_i.ibus, exc_i.dbus, exc_i.div_zero} = 5'h10 >> i;
			else
				exc_i.fpu_flags = 5'($urandom_range(1, 31));
			tick(1);
			expect_ev(EV_HW_EXC, HW_EXC_VECTOR, LINK_HW_EXC, 1'b1);
			`CHK("cause", {20'h0_0000, exc_i.detail, 5'(i + 1)}, estat)
			`CHK("fault", {exc_i.address, 27'h000_0000, exc_i.fpu_flags}, {faddr, fstat})
			`CHK("exc flags", 2'b01, {mstat[BIT_EXC_EN], mstat[BIT_EXC_BUSY]})
			exc_i = '0;
			return_i.from_exception = 1'b1;
			tick(1);
			return_i = '0;
			`CHK("exc return", 2'b10, {mstat[BIT_EXC_EN], mstat[BIT_EXC_BUSY]})
		end
		$display("test exceptions done");
		// exception, break and interrupt at once from a delay slot: order of service decides
		raise = 3'b011;
		tick(2);
		exc_i.ibus = 1'b1;
		exc_i.in_delay_slot = 1'b1;
		tick(1);
		expect_ev(EV_HW_EXC, HW_EXC_VECTOR, LINK_HW_EXC, 1'b1);
		`CHK("unrecoverable", 1'b1, unrecoverable_o)
		exc_i = '0;
		tick(1);
		`CHK("next in order", EV_BREAK, event_o)
		raise = 3'b000;
		$display("test priority done");
		give_verdict();
	end
endmodule
